/* File: rtl/schg_pkg.sv */
// constants and types of the signaling change handler
`default_nettype none
package schg_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFS_DATA_BYTE = 8'h00;
  localparam logic [7:0] OFS_ADDR_SEL = 8'h04;
  localparam logic [7:0] OFS_ACC_CMD = 8'h08;
  localparam logic [7:0] OFS_CHG_FIFO = 8'h0c;
  localparam logic [7:0] OFS_TIMER = 8'h10;
  localparam logic [7:0] OFS_CMD_BITS = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_INT_STATUS = 8'h1c;
  localparam logic [7:0] OFS_MODE = 8'h20;
  // ==========================================
  // field positions
  localparam int BIT_UP_SEL = 7;
  localparam int BIT_START = 6;
  localparam int BIT_FRESET = 4;
  localparam int BIT_ACC_PEND = 7;
  localparam int BIT_TMR_ACT = 6;
  localparam int BIT_IRQ = 6;
  localparam int BIT_OPER = 6;
  // ==========================================
  // operation and channel codes
  localparam logic [3:0] MOC_DATA = 4'h9;
  localparam logic [2:0] MOC_CODE_HI = 3'h7;
  localparam logic [3:0] CODE_SIG6 = 4'ha;
  localparam logic [3:0] CODE_SIG8 = 4'hd;
  localparam logic [3:0] CODE_CI4 = 4'hc;
  localparam logic [3:0] CODE_DN_ODD = 4'hb;
  localparam logic [7:0] PAD_CI = 8'hc3;
  localparam logic [7:0] PAD_SIG6 = 8'h03;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ==========================================
  // sizes and timing
  localparam int UNIT_TIME_US = 250;
  localparam int CLK_MHZ = 100;
  localparam int UNIT_CYCLES = UNIT_TIME_US * CLK_MHZ;
  localparam int FIFO_DEPTH = 9;
  localparam int SLOT_COUNT = 32;
  localparam int CM_DEPTH = 128;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT_NEXT = 3'h1;
  // ==========================================
  // carriers
  typedef struct packed {
    logic [3:0] code;
    logic [7:0] data;
  } schg_cm_type;
  typedef struct packed {
    logic rws;
    logic [3:0] memory_operation_code;
    logic [2:0] low;
  } schg_cmd_type;
  typedef struct packed {
    logic clk;
    logic fsc;
    logic du;
  } schg_link_type;
  typedef struct packed {
    logic fixed;
    logic [6:0] timer_period_value;
  } schg_tmr_type;
endpackage
`default_nettype wire

/* File: rtl/schg_handler.sv */
// signaling change handler: control memory, change fifo, serial frame, apb
`timescale 1ns/10ps
`default_nettype none
module schg_handler
  import schg_pkg::*;
#(
  parameter int unsigned UNIT_CYC = UNIT_CYCLES,
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned SLOTS = SLOT_COUNT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire schg_link_type link_in,
  output logic dd_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int SW = $clog2(UNIT_CYC + 1);
  localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CFULL = CW'(DEPTH);
  localparam logic [SW-1:0] SLAST = SW'(UNIT_CYC - 1);
  localparam logic [6:0] LAST_SLOT = 7'(SLOTS - 1);

  // ==========================================
  // link pin synchroniser and framing
  schg_link_type s1_reg, s2_reg;
  logic clk_prev_reg;
  logic [2:0] bit_reg;
  logic [6:0] slot_reg;
  logic [7:0] rx_sh_reg, tx_sh_reg, rx_byte, tx_byte;
  logic rise, frame_go, byte_done, dd_reg;
  logic [6:0] slot_nx;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      clk_prev_reg <= 1'b0;
    end else begin
      s1_reg <= link_in;
      s2_reg <= s1_reg;
      clk_prev_reg <= s2_reg.clk;
    end
  end

  assign rise = s2_reg.clk & ~clk_prev_reg;
  assign frame_go = rise & s2_reg.fsc;
  assign byte_done = rise & ~s2_reg.fsc & (bit_reg == LAST_BIT);
  assign rx_byte = {rx_sh_reg[6:0], s2_reg.du};
  assign slot_nx = (slot_reg == LAST_SLOT) ? 7'h00 : slot_reg + 7'h01;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bit_reg <= 3'h0;
      slot_reg <= 7'h00;
      rx_sh_reg <= BYTE_ZERO;
    end else if (rise) begin
      rx_sh_reg <= rx_byte;
      if (s2_reg.fsc) begin
        bit_reg <= FIRST_BIT_NEXT;
        slot_reg <= 7'h00;
      end else begin
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == LAST_BIT) begin
          slot_reg <= slot_nx;
        end
      end
    end
  end

  // ==========================================
  // control memory
  schg_cm_type up_mem [CM_DEPTH];
  schg_cm_type dn_mem [CM_DEPTH];
  schg_cmd_type op_reg;
  logic [7:0] op_addr_reg, data_byte_reg, addr_sel_reg;
  logic op_pend_reg, op_go, op_up;
  logic [6:0] op_idx;
  schg_tmr_type timer_reg;
  logic [7:0] mode_reg;
  logic oper;

  assign oper = mode_reg[BIT_OPER];
  assign op_up = op_addr_reg[BIT_UP_SEL];
  assign op_idx = op_addr_reg[6:0];

  // odd slot coded for pass-through repeats the even slot value
  always_comb begin
    logic [6:0] ld;
    ld = slot_nx;
    tx_byte = dn_mem[ld].data;
    if (ld[0] && dn_mem[ld].code == CODE_DN_ODD) begin
      tx_byte = dn_mem[{ld[6:1], 1'b0}].data;
    end
  end

  // next bit is driven right after the sampled edge, ready for the next one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_sh_reg <= 8'hff;
      dd_reg <= 1'b1;
    end else if (rise) begin
      if (!s2_reg.fsc && bit_reg == LAST_BIT) begin
        tx_sh_reg <= {tx_byte[6:0], 1'b1};
        dd_reg <= tx_byte[7] | ~oper;
      end else begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
        dd_reg <= tx_sh_reg[7] | ~oper;
      end
    end
  end
  assign dd_out = dd_reg;

  // ==========================================
  // upstream change detection
  logic [6:0] ev_idx;
  schg_cm_type ev_ent, od_ent;
  logic eng_act, is_ci, is_sig, act_wr, stab_wr, push_en, full, sample_frame_reg;
  logic [7:0] val, push_data;

  assign ev_idx = {slot_reg[6:1], 1'b0};
  assign ev_ent = up_mem[ev_idx];
  assign od_ent = up_mem[slot_reg];
  assign eng_act = byte_done & slot_reg[0] & oper;
  assign is_ci = ev_ent.code == CODE_CI4;
  assign is_sig = (ev_ent.code == CODE_SIG6) || (ev_ent.code == CODE_SIG8);

  always_comb begin
    val = rx_byte;
    if (is_ci) begin
      val = rx_byte | PAD_CI;
    end else if (ev_ent.code == CODE_SIG6) begin
      val = rx_byte | PAD_SIG6;
    end
  end

  // a change met by a full fifo leaves the reported entry alone and is seen again later; a six/eight-bit first look still writes the even slot
  assign act_wr = eng_act & ((is_ci & (val != ev_ent.data) & ~full)
                  | (is_sig & sample_frame_reg));
  assign stab_wr = eng_act & is_sig & sample_frame_reg & (val == ev_ent.data)
                   & (val != od_ent.data) & ~full;
  assign push_en = (act_wr & is_ci) | stab_wr;
  assign push_data = {1'b1, is_ci ? ev_idx : slot_reg};
  assign op_go = op_pend_reg & ~(act_wr | stab_wr);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CM_DEPTH; i++) begin
        up_mem[i] <= '0;
        dn_mem[i] <= '0;
      end
    end else begin
      if (act_wr) begin
        up_mem[ev_idx].data <= val;
      end
      if (stab_wr) begin
        up_mem[slot_reg].data <= val;
      end
      if (op_go && !op_reg.rws) begin
        if (op_reg.memory_operation_code == MOC_DATA) begin
          if (op_up) begin
            up_mem[op_idx].data <= data_byte_reg;
          end else begin
            dn_mem[op_idx].data <= data_byte_reg;
          end
        end else if (op_reg.memory_operation_code[3:1] == MOC_CODE_HI) begin
          if (op_up) begin
            up_mem[op_idx] <= {op_reg.memory_operation_code[0], op_reg.low, data_byte_reg};
          end else begin
            dn_mem[op_idx] <= {op_reg.memory_operation_code[0], op_reg.low, data_byte_reg};
          end
        end
      end
    end
  end

  // ==========================================
  // timer and sampling period
  logic tmr_act_reg, tick, tick_pend_reg;
  logic [SW-1:0] sub_reg;
  logic [6:0] unit_reg;
  logic wr_fin, rd_acc, cmd_wr, fifo_reset_cmd;

  assign tick = tmr_act_reg & (sub_reg == SLAST) & (unit_reg == timer_reg.timer_period_value);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tmr_act_reg <= 1'b0;
      sub_reg <= '0;
      unit_reg <= 7'h00;
    end else begin
      if (!oper || (wr_fin && paddr == OFS_TIMER)) begin
        tmr_act_reg <= 1'b0;
      end else if (cmd_wr && pwdata[BIT_START]) begin
        tmr_act_reg <= 1'b1;
      end
      if (!tmr_act_reg || sub_reg == SLAST) begin
        sub_reg <= '0;
      end else begin
        sub_reg <= sub_reg + SW'(1);
      end
      if (!tmr_act_reg || tick) begin
        unit_reg <= 7'h00;
      end else if (sub_reg == SLAST) begin
        unit_reg <= unit_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_pend_reg <= 1'b0;
      sample_frame_reg <= 1'b0;
    end else if (frame_go) begin
      tick_pend_reg <= 1'b0;
      sample_frame_reg <= timer_reg.fixed | tick_pend_reg | tick;
    end else if (tick) begin
      tick_pend_reg <= 1'b1;
    end
  end

  // ==========================================
  // change address fifo
  logic [7:0] fifo_mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic pop, pop_ok_reg, sfi_reg;

  assign full = cnt_reg == CFULL;
  assign pop = wr_fin == 1'b0 && rd_acc && pop_ok_reg;
  assign cnt_next = fifo_reset_cmd ? '0 : cnt_reg + CW'(push_en) - CW'(pop);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      sfi_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      sfi_reg <= cnt_next != '0;
      if (fifo_reset_cmd) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else begin
        if (push_en) begin
          fifo_mem[wr_ptr_reg] <= push_data;
          wr_ptr_reg <= (wr_ptr_reg == PLAST) ? '0 : wr_ptr_reg + PW'(1);
        end
        if (pop) begin
          rd_ptr_reg <= (rd_ptr_reg == PLAST) ? '0 : rd_ptr_reg + PW'(1);
        end
      end
    end
  end

  // ==========================================
  // apb slave, one wait state on every transfer
  logic acc1, bad, pready_reg, pslverr_reg;
  logic [7:0] rd_mux;
  logic [31:0] prdata_reg;

  assign acc1 = psel & penable & ~pready_reg;
  assign wr_fin = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign rd_acc = psel & penable & pready_reg & (paddr == OFS_CHG_FIFO);
  assign cmd_wr = wr_fin & (paddr == OFS_CMD_BITS);
  assign fifo_reset_cmd = cmd_wr & pwdata[BIT_FRESET];

  always_comb begin
    rd_mux = BYTE_ZERO;
    bad = 1'b0;
    if (paddr == OFS_DATA_BYTE) begin
      rd_mux = data_byte_reg;
    end else if (paddr == OFS_ADDR_SEL) begin
      rd_mux = addr_sel_reg;
    end else if (paddr == OFS_ACC_CMD) begin
      rd_mux = op_reg;
    end else if (paddr == OFS_CHG_FIFO) begin
      rd_mux = (cnt_reg != '0) ? fifo_mem[rd_ptr_reg] : BYTE_ZERO;
    end else if (paddr == OFS_TIMER) begin
      rd_mux = timer_reg;
    end else if (paddr == OFS_CMD_BITS) begin
      rd_mux = BYTE_ZERO;
    end else if (paddr == OFS_STATE) begin
      rd_mux[BIT_ACC_PEND] = op_pend_reg;
      rd_mux[BIT_TMR_ACT] = tmr_act_reg;
    end else if (paddr == OFS_INT_STATUS) begin
      rd_mux[BIT_IRQ] = sfi_reg;
    end else if (paddr == OFS_MODE) begin
      rd_mux = mode_reg;
    end else begin
      bad = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      pop_ok_reg <= 1'b0;
    end else begin
      pready_reg <= acc1;
      pslverr_reg <= acc1 & bad;
      prdata_reg <= (acc1 && !pwrite) ? {24'h000000, rd_mux} : '0;
      pop_ok_reg <= acc1 & ~pwrite & (paddr == OFS_CHG_FIFO) & (cnt_reg != '0);
    end
  end
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // access command is queued; it yields to the upstream engine for a cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_byte_reg <= BYTE_ZERO;
      addr_sel_reg <= BYTE_ZERO;
      op_reg <= '0;
      op_addr_reg <= BYTE_ZERO;
      op_pend_reg <= 1'b0;
      timer_reg <= '0;
      mode_reg <= BYTE_ZERO;
    end else begin
      if (op_go && op_reg.rws) begin
        data_byte_reg <= op_up ? up_mem[op_idx].data : dn_mem[op_idx].data;
      end else if (wr_fin && paddr == OFS_DATA_BYTE) begin
        data_byte_reg <= pwdata[7:0];
      end
      if (wr_fin && paddr == OFS_ADDR_SEL) begin
        addr_sel_reg <= pwdata[7:0];
      end
      if (wr_fin && paddr == OFS_ACC_CMD) begin
        op_reg <= pwdata[7:0];
        op_addr_reg <= addr_sel_reg;
        op_pend_reg <= 1'b1;
      end else if (op_go) begin
        op_pend_reg <= 1'b0;
      end
      if (wr_fin && paddr == OFS_TIMER) begin
        timer_reg <= pwdata[7:0];
      end
      if (wr_fin && paddr == OFS_MODE) begin
        mode_reg <= pwdata[7:0];
      end
    end
  end

  // ==========================================
  // checks
  a_fifo_no_overrun: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cnt_reg <= CFULL && !(push_en && full)) else $error("fifo overrun");
  a_entry_msb: assert property (@(posedge ref_clk) disable iff (sys_rst)
    push_en |-> push_data[7]) else $error("entry msb clear");
  a_ci_even_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    push_en && is_ci |-> !push_data[0] && act_wr) else $error("ci addr");
  a_stable_odd: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stab_wr |-> push_en && push_data[0] ##1 cnt_reg != '0) else $error("stable");
  a_double_look: assert property (@(posedge ref_clk) disable iff (sys_rst)
    stab_wr |=> up_mem[$past(slot_reg)].data == $past(ev_ent.data))
    else $error("stable value");
  a_idle_ignore: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !oper |-> !act_wr && !stab_wr && !push_en) else $error("idle write");
  a_timer_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    frame_go && !timer_reg.fixed && !tick_pend_reg && !tick |=> !sample_frame_reg)
    else $error("sample without timer");
  a_pend_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_fin && paddr == OFS_ACC_CMD |=> op_pend_reg ##[1:3] !op_pend_reg)
    else $error("access flag");
  a_reset_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fifo_reset_cmd |=> cnt_reg == '0 && !sfi_reg) else $error("fifo reset");
  a_irq_tracks: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sfi_reg == (cnt_reg != '0)) else $error("irq flag");
  c_push: cover property (@(posedge ref_clk) disable iff (sys_rst) push_en);
  c_full: cover property (@(posedge ref_clk) disable iff (sys_rst) full);
  c_stable: cover property (@(posedge ref_clk) disable iff (sys_rst) stab_wr);
  c_readback: cover property (@(posedge ref_clk) disable iff (sys_rst)
    op_go && op_reg.rws);
endmodule
`default_nettype wire

/* File: dv/schg_line_model.sv */
// serial frame model of the line-card subscriber circuits
`timescale 1ns/10ps
`default_nettype none
module schg_line_model
  import schg_pkg::*;
#(
  parameter int SLOTS = 8,
  parameter int ODD_SLOT = 7
) (
  output var schg_link_type link_out,
  input wire logic dd_in,
  input wire logic [7:0] up_byte,
  output logic [7:0] dn_byte,
  output logic [15:0] frame_cnt
);
  // ==========================================
  // frame generator, 160 ns bit clock
  logic [7:0] tx;
  logic [7:0] sh;
  initial begin
    link_out = 3'b001;
    dn_byte = 8'hff;
    frame_cnt = 16'h0000;
    sh = 8'hff;
    // odd offset keeps the bit clock out of phase with ref_clk
    #3.3;
    forever begin
      for (int s = 0; s < SLOTS; s++) begin
        // idle slots float high through the line pull-up
        tx = (s == ODD_SLOT) ? up_byte : 8'hff;
        for (int b = 0; b < 8; b++) begin
          link_out.clk = 1'b0;
          link_out.fsc = (s == 0 && b == 0);
          link_out.du = tx[7 - b];
          // dd bit was launched after the previous rise
          sh = {sh[6:0], dd_in};
          #80;
          link_out.clk = 1'b1;
          #80;
        end
        if (s == ODD_SLOT) begin
          dn_byte = sh;
        end
      end
      frame_cnt = frame_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* File: dv/test_schg_handler.sv */
// self-checking bench of the signaling change handler
`timescale 1ns/10ps
`default_nettype none
module test_schg_handler;
  import schg_pkg::*;
  // short timer unit keeps timer-paced sampling inside a few frames
  localparam int UNIT = 40;
  localparam int LIMIT = 80000;
  localparam logic [7:0] IRQ_SET = 8'h01 << BIT_IRQ;
  localparam logic [7:0] RST_OFS [9] = '{OFS_DATA_BYTE, OFS_ADDR_SEL, OFS_ACC_CMD,
    OFS_CHG_FIFO, OFS_TIMER, OFS_CMD_BITS, OFS_STATE, OFS_INT_STATUS, OFS_MODE};
  logic ref_clk;
  logic sys_rst;
  logic psel, penable, pwrite, pready, pslverr, dd_out, perr;
  logic [7:0] paddr, up_byte, dn_byte;
  logic [31:0] pwdata, prdata, v;
  logic [15:0] frame_cnt;
  schg_link_type link;
  int n_fail;
  int tests_run;
  int cyc;

  schg_handler #(.UNIT_CYC(UNIT), .DEPTH(9), .SLOTS(8)) schg_handler_inst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link_in(link),
    .dd_out(dd_out)
  );
  schg_line_model #(.SLOTS(8), .ODD_SLOT(7)) schg_line_model_inst (
    .link_out(link),
    .dd_in(dd_out),
    .up_byte(up_byte),
    .dn_byte(dn_byte),
    .frame_cnt(frame_cnt)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========================================
  // watchdog
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  // ==========================================
  // tasks
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    check(r, {24'h000000, exp});
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    logic e;
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATE, 8'h00, s, e);
      k++;
    end while (s[BIT_ACC_PEND] !== 1'b0 && k < 20);
    check({31'h0, s[BIT_ACC_PEND]}, 32'h0);
  endtask
  task automatic cm_write(input logic [7:0] a, input logic full, input logic [3:0] code,
                          input logic [7:0] d);
    wr(OFS_DATA_BYTE, d);
    wr(OFS_ADDR_SEL, a);
    wr(OFS_ACC_CMD, full ? {1'b0, MOC_CODE_HI, code} : {1'b0, MOC_DATA, 3'h0});
    wait_idle();
  endtask
  task automatic cm_read(input logic [7:0] a, input logic [7:0] exp);
    wr(OFS_ADDR_SEL, a);
    wr(OFS_ACC_CMD, {1'b1, MOC_DATA, 3'h0});
    wait_idle();
    expect_reg(OFS_DATA_BYTE, exp);
  endtask
  task automatic wait_frames(input int n);
    repeat (n) @(frame_cnt);
    @(posedge ref_clk);
  endtask
  // ==========================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    up_byte = 8'h30;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (RST_OFS[i]) expect_reg(RST_OFS[i], BYTE_ZERO);
    apb(1'b1, 8'h24, 8'h5a, v, perr);
    check({31'h0, perr}, 32'h1);
    apb(1'b0, 8'h24, 8'h00, v, perr);
    check({31'h0, perr}, 32'h1);
    check(v, 32'h0);
    $display("test reset_and_refusal done");
    // interface idle: nothing stored, downstream stays high
    wr(OFS_MODE, 8'h80);
    cm_write(8'h06, 1'b1, CODE_SIG6, 8'h57);
    cm_write(8'h07, 1'b1, CODE_DN_ODD, 8'hff);
    // slots coded and sampled each frame, so only the idle gate keeps 30 out
    cm_write(8'h86, 1'b1, CODE_SIG6, 8'h77);
    cm_write(8'h87, 1'b1, CODE_SIG6, 8'h77);
    wr(OFS_TIMER, 8'h80);
    wait_frames(2);
    cm_read(8'h86, 8'h77);
    cm_read(8'h87, 8'h77);
    expect_reg(OFS_INT_STATUS, BYTE_ZERO);
    check({24'h0, dn_byte}, 32'hff);
    up_byte <= 8'h74;
    wr(OFS_MODE, 8'hee);
    wait_frames(3);
    expect_reg(OFS_INT_STATUS, BYTE_ZERO);
    check({24'h0, dn_byte}, 32'h57);
    cm_write(8'h06, 1'b0, 4'h0, 8'hcf);
    wait_frames(2);
    check({24'h0, dn_byte}, 32'hcf);
    cm_read(8'h06, 8'hcf);
    $display("test downstream_and_preload done");
    up_byte <= 8'h30;
    wait_frames(3);
    expect_reg(OFS_INT_STATUS, IRQ_SET);
    expect_reg(OFS_INT_STATUS, IRQ_SET);
    expect_reg(OFS_CHG_FIFO, 8'h87);
    expect_reg(OFS_INT_STATUS, BYTE_ZERO);
    cm_read(8'h87, 8'h33);
    cm_read(8'h86, 8'h33);
    wait_frames(1);
    up_byte <= 8'h50;
    wait_frames(1);
    up_byte <= 8'h30;
    wait_frames(3);
    expect_reg(OFS_CHG_FIFO, BYTE_ZERO);
    cm_read(8'h87, 8'h33);
    $display("test six_bit_change done");
    wr(OFS_TIMER, 8'h01);
    expect_reg(OFS_STATE, BYTE_ZERO);
    up_byte <= 8'h74;
    wait_frames(3);
    expect_reg(OFS_CHG_FIFO, BYTE_ZERO);
    wr(OFS_CMD_BITS, 8'h40);
    expect_reg(OFS_STATE, 8'h40);
    wait_frames(3);
    expect_reg(OFS_CHG_FIFO, 8'h87);
    cm_read(8'h87, 8'h77);
    // longest period spans five frames, so a change needs two of them
    wr(OFS_TIMER, 8'h7f);
    wr(OFS_CMD_BITS, 8'h40);
    up_byte <= 8'h30;
    wait_frames(4);
    expect_reg(OFS_CHG_FIFO, BYTE_ZERO);
    wait_frames(10);
    expect_reg(OFS_CHG_FIFO, 8'h87);
    $display("test timer_sampling done");
    wr(OFS_TIMER, 8'h00);
    expect_reg(OFS_STATE, BYTE_ZERO);
    up_byte <= 8'h14;
    cm_write(8'h86, 1'b1, CODE_CI4, 8'hd7);
    wait_frames(2);
    expect_reg(OFS_CHG_FIFO, BYTE_ZERO);
    up_byte <= 8'h28;
    wait_frames(2);
    expect_reg(OFS_CHG_FIFO, 8'h86);
    cm_read(8'h86, 8'heb);
    $display("test four_bit_change done");
    wait_frames(1);
    for (int i = 0; i < 10; i++) begin
      up_byte <= i[0] ? 8'h28 : 8'h14;
      wait_frames(1);
    end
    expect_reg(OFS_INT_STATUS, IRQ_SET);
    repeat (9) expect_reg(OFS_CHG_FIFO, 8'h86);
    expect_reg(OFS_CHG_FIFO, BYTE_ZERO);
    cm_read(8'h86, 8'hd7);
    wait_frames(2);
    expect_reg(OFS_CHG_FIFO, 8'h86);
    cm_read(8'h86, 8'heb);
    up_byte <= 8'h14;
    wait_frames(1);
    up_byte <= 8'h28;
    wait_frames(1);
    expect_reg(OFS_INT_STATUS, IRQ_SET);
    wr(OFS_CMD_BITS, 8'h10);
    expect_reg(OFS_INT_STATUS, BYTE_ZERO);
    expect_reg(OFS_CHG_FIFO, BYTE_ZERO);
    $display("test fifo_depth_and_reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
